// >>> hw/tcu8_pkg.sv
// Package of constants and types for the 8-bit timer compare unit.
package tcu8_pkg;
  localparam logic [7:0] tcu8_bottom = 8'h00;
  localparam logic [7:0] tcu8_max = 8'hff;
  localparam logic [7:0] tcu8_count_rst = 8'h00;
  localparam logic [7:0] tcu8_compare_rst = 8'h00;
  localparam logic [2:0] tcu8_cs_stopped = 3'h0;
  localparam logic [2:0] tcu8_cs_div1 = 3'h1;
  localparam logic [2:0] tcu8_cs_div8 = 3'h2;
  localparam logic [2:0] tcu8_cs_div32 = 3'h3;
  localparam logic [2:0] tcu8_cs_div64 = 3'h4;
  localparam logic [2:0] tcu8_cs_div128 = 3'h5;
  localparam logic [2:0] tcu8_cs_div256 = 3'h6;
  localparam logic [2:0] tcu8_cs_div1024 = 3'h7;
  localparam logic [1:0] tcu8_wgm_normal = 2'h0;
  localparam logic [1:0] tcu8_wgm_phase_pwm = 2'h1;
  localparam logic [1:0] tcu8_wgm_ctc = 2'h2;
  localparam logic [1:0] tcu8_wgm_fast_pwm = 2'h3;
  localparam logic [1:0] tcu8_com_none = 2'h0;
  localparam logic [1:0] tcu8_com_toggle = 2'h1;
  localparam logic [1:0] tcu8_com_clear = 2'h2;
  localparam logic [1:0] tcu8_com_set = 2'h3;
  localparam int tcu8_presc_width = 10;
  localparam logic [9:0] tcu8_presc_rst = 10'h000;
  typedef enum logic {tcu8_dir_up, tcu8_dir_down} tcu8_dir_t;
endpackage

// >>> hw/tcu8_timer.sv
// Eight-bit timer/counter with one compare channel and waveform output.
//
// Contract
// - Counter, compare register and comparator are all eight bits wide.
// - Clock select zero gives no tick; counter stays stopped.
// - Tick comes from I/O clock, or crystal oscillator when async select set.
// - Bottom indication is high whenever the counter is zero.
// - Maximum is 0xff; max indication high when counter equals it.
// - Top is 0xff or the compare value, chosen by mode.
// - Each tick clears, increments or decrements counter per mode and direction.
// - CPU may read and write the counter at any time.
// - CPU counter write beats a simultaneous clear or count.
// - Waveform mode bits choose count sequence and overflow flag timing.
// - Comparator asserts match whenever counter equals active compare value.
// - Match sets compare flag on the following tick.
// - Compare flag with enable set raises compare interrupt request.
// - Compare flag clears on interrupt service or software writing one.
// - Waveform output built from match, mode, output mode, max and bottom.
// - Compare value double-buffered in PWM modes, direct otherwise.
// - Buffered value moves to active register only at max, in both PWM modes.
// - Force strobe in non-PWM modes acts on output like a real match.
// - Forced compare sets no flag and does not clear the counter.
// - Counter write blocks any match in the next tick cycle, even stopped.
// - Output state keeps its value across waveform mode changes.
// - Output mode field is unbuffered and takes effect immediately.
// - Output mode zero means no output action; nonzero overrides port data.
// - Pin direction bit still decides whether the pin is driven.
`timescale 1ns/1ps
module tcu8_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Clock source control
  input wire logic [2:0] clock_select_field,
  input wire logic async_clock_select,
  input wire logic crystal_pin_one,
  // Mode control
  input wire logic [1:0] waveform_mode_field,
  input wire logic [1:0] compare_output_mode_field,
  input wire logic force_compare_strobe,
  // Counter access
  input wire logic counter_write,
  input wire logic [7:0] counter_wdata,
  output logic [7:0] counter_value,
  // Compare access
  input wire logic compare_write,
  input wire logic [7:0] compare_wdata,
  output logic [7:0] compare_value,
  // Flags and interrupt
  input wire logic compare_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic compare_flag_clear,
  input wire logic overflow_irq_ack,
  input wire logic overflow_flag_clear,
  output logic compare_flag,
  output logic overflow_flag,
  output logic compare_irq,
  // Pin
  input wire logic compare_pin_direction,
  input wire logic port_data,
  output logic compare_pin_out,
  output logic compare_pin_oe
);

  logic xtal_meta;
  logic xtal_sync;
  logic xtal_prev;
  logic [9:0] presc;
  logic presc_src;
  logic tick;
  logic [7:0] compare_buffer;
  logic [7:0] compare_active;
  tcu8_pkg::tcu8_dir_t dir;
  logic block_match;
  logic match_pending;
  logic oc_state;
  logic next_oc;
  logic is_pwm;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic match;
  logic [7:0] top_value;
  logic [9:0] tap_mask;

  function automatic logic is_pwm_mode(input logic [1:0] wgm);
    is_pwm_mode = (wgm == tcu8_pkg::tcu8_wgm_phase_pwm) ||
                  (wgm == tcu8_pkg::tcu8_wgm_fast_pwm);
  endfunction

  // Rising crystal edges are counted as ticks after a two-stage synchroniser.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_meta <= crystal_pin_one;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  // Prescaler source is the I/O clock or a rising crystal edge.
  always_comb begin
    presc_src = 1'b1;
    if (async_clock_select) begin
      presc_src = xtal_sync && !xtal_prev;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc <= tcu8_pkg::tcu8_presc_rst;
    end else if (clock_select_field == tcu8_pkg::tcu8_cs_stopped) begin
      presc <= tcu8_pkg::tcu8_presc_rst;
    end else if (presc_src) begin
      presc <= presc + 10'h001;
    end
  end

  // A tick fires when every prescaler bit below the chosen tap is one.
  always_comb begin
    case (clock_select_field)
      tcu8_pkg::tcu8_cs_div1: tap_mask = 10'h000;
      tcu8_pkg::tcu8_cs_div8: tap_mask = 10'h007;
      tcu8_pkg::tcu8_cs_div32: tap_mask = 10'h01f;
      tcu8_pkg::tcu8_cs_div64: tap_mask = 10'h03f;
      tcu8_pkg::tcu8_cs_div128: tap_mask = 10'h07f;
      tcu8_pkg::tcu8_cs_div256: tap_mask = 10'h0ff;
      tcu8_pkg::tcu8_cs_div1024: tap_mask = 10'h3ff;
      default: tap_mask = 10'h000;
    endcase
    tick = presc_src && ((presc & tap_mask) == tap_mask) &&
           (clock_select_field != tcu8_pkg::tcu8_cs_stopped);
  end

  assign is_pwm = is_pwm_mode(waveform_mode_field);
  assign at_bottom = (counter_value == tcu8_pkg::tcu8_bottom);
  assign at_max = (counter_value == tcu8_pkg::tcu8_max);
  assign match = (counter_value == compare_active);

  always_comb begin
    if (waveform_mode_field == tcu8_pkg::tcu8_wgm_ctc) begin
      top_value = compare_active;
    end else begin
      top_value = tcu8_pkg::tcu8_max;
    end
    at_top = (counter_value == top_value);
  end

  // Counter sequence per waveform mode; CPU write has priority.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_value <= tcu8_pkg::tcu8_count_rst;
    end else if (counter_write) begin
      counter_value <= counter_wdata;
    end else if (tick) begin
      case (waveform_mode_field)
        tcu8_pkg::tcu8_wgm_ctc: begin
          if (at_top) begin
            counter_value <= tcu8_pkg::tcu8_bottom;
          end else begin
            counter_value <= counter_value + 8'h01;
          end
        end
        tcu8_pkg::tcu8_wgm_phase_pwm: begin
          if ((dir == tcu8_pkg::tcu8_dir_up && !at_max) || at_bottom) begin
            counter_value <= counter_value + 8'h01;
          end else begin
            counter_value <= counter_value - 8'h01;
          end
        end
        default: begin
          counter_value <= counter_value + 8'h01;
        end
      endcase
    end
  end

  // Count direction for the dual-slope mode turns at max and bottom.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir <= tcu8_pkg::tcu8_dir_up;
    end else if (waveform_mode_field != tcu8_pkg::tcu8_wgm_phase_pwm) begin
      dir <= tcu8_pkg::tcu8_dir_up;
    end else if (tick && !counter_write) begin
      if (at_max) begin
        dir <= tcu8_pkg::tcu8_dir_down;
      end else if (at_bottom) begin
        dir <= tcu8_pkg::tcu8_dir_up;
      end
    end
  end

  // In PWM modes writes land in the buffer and move at max (top).
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_buffer <= tcu8_pkg::tcu8_compare_rst;
    end else if (compare_write) begin
      compare_buffer <= compare_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_active <= tcu8_pkg::tcu8_compare_rst;
    end else if (!is_pwm) begin
      if (compare_write) begin
        compare_active <= compare_wdata;
      end
    end else if (tick) begin
      if ((waveform_mode_field == tcu8_pkg::tcu8_wgm_fast_pwm && at_max) ||
          (waveform_mode_field == tcu8_pkg::tcu8_wgm_phase_pwm && at_max)) begin
        compare_active <= compare_buffer;
      end
    end
  end

  // Software sees the buffer in PWM modes and the live register otherwise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_value <= tcu8_pkg::tcu8_compare_rst;
    end else if (is_pwm) begin
      compare_value <= compare_write ? compare_wdata : compare_buffer;
    end else begin
      compare_value <= compare_write ? compare_wdata : compare_active;
    end
  end

  // A counter write blocks matches until the next tick has passed.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      block_match <= 1'b0;
    end else if (counter_write) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // Match is latched on one tick and raises the flag on the next.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_pending <= 1'b0;
    end else if (tick) begin
      match_pending <= match && !block_match && !counter_write;
    end
  end

  // Hardware set wins over a clear arriving in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_flag <= 1'b0;
    end else if (tick && match_pending) begin
      compare_flag <= 1'b1;
    end else if (compare_irq_ack || compare_flag_clear) begin
      compare_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_irq <= 1'b0;
    end else begin
      compare_irq <= compare_irq_enable && (compare_flag ||
                     (tick && match_pending));
    end
  end

  // Overflow timing follows the waveform mode.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (tick && !counter_write &&
                 ((waveform_mode_field == tcu8_pkg::tcu8_wgm_phase_pwm) ?
                  at_bottom : at_max)) begin
      overflow_flag <= 1'b1;
    end else if (overflow_irq_ack || overflow_flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // Output state update from match, force strobe and extreme values.
  always_comb begin
    next_oc = oc_state;
    if (!is_pwm) begin
      if ((tick && match && !block_match && !counter_write) ||
          force_compare_strobe) begin
        case (compare_output_mode_field)
          tcu8_pkg::tcu8_com_toggle: next_oc = !oc_state;
          tcu8_pkg::tcu8_com_clear: next_oc = 1'b0;
          tcu8_pkg::tcu8_com_set: next_oc = 1'b1;
          default: next_oc = oc_state;
        endcase
      end
    end else if (tick && compare_output_mode_field[1]) begin
      if (waveform_mode_field == tcu8_pkg::tcu8_wgm_fast_pwm) begin
        if (at_max) begin
          next_oc = !compare_output_mode_field[0];
        end else if (match && !block_match && !counter_write) begin
          next_oc = compare_output_mode_field[0];
        end
      end else if (match && !block_match && !counter_write) begin
        next_oc = (dir == tcu8_pkg::tcu8_dir_up) ^ !compare_output_mode_field[0];
      end
    end
  end

  // Mode changes never reset the output state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_state <= 1'b0;
    end else begin
      oc_state <= next_oc;
    end
  end

  // Pin drive: port data unless output mode is nonzero; direction gates.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compare_pin_out <= 1'b0;
      compare_pin_oe <= 1'b0;
    end else begin
      compare_pin_out <= (compare_output_mode_field != tcu8_pkg::tcu8_com_none) ?
                         next_oc : port_data;
      compare_pin_oe <= compare_pin_direction;
    end
  end

endmodule

// >>> sim/tcu8_far_side.sv
// Far-side model: watch crystal source and the load on the compare pin.
`timescale 1ns/1ps
module tcu8_far_side #(
  parameter int half_ns = 250
) (
  // Crystal
  input wire logic crystal_run,
  output logic crystal_pin_one,
  // Compare pin
  input wire logic compare_pin_out,
  input wire logic compare_pin_oe,
  output logic pin_level
);
  logic last_level = 1'b0;
  // The crystal is far faster than a real watch crystal to keep the run short.
  initial begin
    crystal_pin_one = 1'b0;
    forever begin
      #(half_ns);
      if (crystal_run) begin
        crystal_pin_one = ~crystal_pin_one;
      end
    end
  end
  always @(compare_pin_out or compare_pin_oe) begin
    if (compare_pin_oe) begin
      last_level = compare_pin_out;
    end
  end
  // A released pin has no pull, so it shows the opposite of its last driven level.
  assign pin_level = compare_pin_oe ? compare_pin_out : ~last_level;
endmodule

// >>> sim/tcu8_monitor.sv
// Checker of counting, compare flag and pin enable behaviour of the timer.
`timescale 1ns/1ps
module tcu8_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controls
  input wire logic [2:0] clock_select_field,
  input wire logic async_clock_select,
  input wire logic [1:0] waveform_mode_field,
  input wire logic force_compare_strobe,
  input wire logic counter_write,
  input wire logic compare_write,
  input wire logic compare_flag_clear,
  input wire logic compare_pin_direction,
  // Observed
  input wire logic [7:0] counter_value,
  input wire logic [7:0] compare_value,
  input wire logic compare_flag,
  input wire logic compare_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic run1;
  logic idle;
  assign run1 = clock_select_field == tcu8_pkg::tcu8_cs_div1 && !async_clock_select;
  assign idle = clock_select_field == tcu8_pkg::tcu8_cs_stopped && !counter_write;
  sequence s_match;
    run1 && !waveform_mode_field[0] && counter_value == compare_value && !counter_write
      && !compare_write && !$past(counter_write);
  endsequence
  sequence s_write_equal;
    counter_write && counter_value != compare_value ##1 run1 && !counter_write && !compare_write
      && waveform_mode_field == tcu8_pkg::tcu8_wgm_normal && counter_value == compare_value
      && !compare_flag;
  endsequence
  a_stop_holds: assert property (idle && $past(clock_select_field) == 3'h0 |=> $stable(counter_value))
    else $error("counter moved while stopped");
  a_count_up: assert property (run1 && waveform_mode_field == 2'h0 && !counter_write
    |=> counter_value == 8'($past(counter_value) + 8'h01)) else $error("normal count wrong");
  a_ctc_clear: assert property (s_match and waveform_mode_field == 2'h2 |=> counter_value == 8'h00)
    else $error("no clear at compare top");
  a_match_flag: assert property (s_match ##1 run1 |=> compare_flag)
    else $error("flag not set after match");
  a_write_block: assert property (s_write_equal |=> !compare_flag [*2])
    else $error("blocked match set flag");
  a_flag_clear: assert property (compare_flag_clear && idle |=> !compare_flag)
    else $error("flag not cleared");
  a_pin_enable: assert property ($past(rst_b) |-> compare_pin_oe == $past(compare_pin_direction))
    else $error("pin enable not following direction");
  a_force_quiet: assert property (force_compare_strobe && idle && !compare_flag
    |=> !compare_flag && $stable(counter_value)) else $error("force changed flag or counter");
endmodule
bind tcu8_timer tcu8_monitor u_monitor (.clk(clk), .rst_b(rst_b),
  .clock_select_field(clock_select_field), .async_clock_select(async_clock_select),
  .waveform_mode_field(waveform_mode_field), .force_compare_strobe(force_compare_strobe),
  .counter_write(counter_write), .compare_write(compare_write),
  .compare_flag_clear(compare_flag_clear), .compare_pin_direction(compare_pin_direction),
  .counter_value(counter_value), .compare_value(compare_value), .compare_flag(compare_flag),
  .compare_pin_oe(compare_pin_oe));

// >>> sim/testbench.sv
// Self-checking testbench of the eight-bit timer compare unit.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] clock_select_field = 3'h0;
  logic async_clock_select = 1'b0;
  logic [1:0] waveform_mode_field = 2'h0;
  logic [1:0] compare_output_mode_field = 2'h0;
  logic force_compare_strobe = 1'b0;
  logic counter_write = 1'b0;
  logic [7:0] counter_wdata = 8'h00;
  logic compare_write = 1'b0;
  logic [7:0] compare_wdata = 8'h00;
  logic compare_irq_enable = 1'b0;
  logic compare_irq_ack = 1'b0;
  logic compare_flag_clear = 1'b0;
  logic overflow_flag_clear = 1'b0;
  logic compare_pin_direction = 1'b0;
  logic port_data = 1'b0;
  logic crystal_run = 1'b0;
  logic crystal_pin_one;
  logic [7:0] counter_value;
  logic [7:0] compare_value;
  logic compare_flag, overflow_flag, compare_irq, compare_pin_out, compare_pin_oe, pin_level;
  int err_count = 0;
  int cmp_count = 0;
  int divisor [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  tcu8_timer uut (.clk(clk), .rst_b(rst_b), .clock_select_field(clock_select_field),
    .async_clock_select(async_clock_select), .crystal_pin_one(crystal_pin_one),
    .waveform_mode_field(waveform_mode_field), .force_compare_strobe(force_compare_strobe),
    .compare_output_mode_field(compare_output_mode_field), .counter_write(counter_write),
    .counter_wdata(counter_wdata), .counter_value(counter_value), .compare_write(compare_write),
    .compare_wdata(compare_wdata), .compare_value(compare_value),
    .compare_irq_enable(compare_irq_enable), .compare_irq_ack(compare_irq_ack),
    .compare_flag_clear(compare_flag_clear), .overflow_irq_ack(1'b0),
    .overflow_flag_clear(overflow_flag_clear), .compare_flag(compare_flag),
    .overflow_flag(overflow_flag), .compare_irq(compare_irq), .port_data(port_data),
    .compare_pin_direction(compare_pin_direction), .compare_pin_out(compare_pin_out),
    .compare_pin_oe(compare_pin_oe));
  tcu8_far_side far (.crystal_run(crystal_run), .crystal_pin_one(crystal_pin_one),
    .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe), .pin_level(pin_level));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Order of bits: force, interrupt service, compare flag clear, overflow flag clear.
  task automatic pulse(input int k);
    {force_compare_strobe, compare_irq_ack, compare_flag_clear, overflow_flag_clear} = 4'h8 >> k;
    step(1);
    {force_compare_strobe, compare_irq_ack, compare_flag_clear, overflow_flag_clear} = 4'h0;
  endtask
  task automatic wr_cnt(input logic [7:0] v);
    counter_write = 1'b1;
    counter_wdata = v;
    step(1);
    counter_write = 1'b0;
  endtask
  task automatic wr_cmp(input logic [7:0] v);
    compare_write = 1'b1;
    compare_wdata = v;
    step(1);
    compare_write = 1'b0;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_basic;
    check("counter reset", counter_value, 8'h00);
    check("compare reset", compare_value, 8'h00);
    wr_cnt(8'h5a);
    step(5);
    check("stopped counter", counter_value, 8'h5a);
    pulse(3);
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    wr_cnt(8'hfd);
    check("write over tick", counter_value, 8'hfd);
    step(3);
    check("wrapped count", counter_value, 8'h00);
    check("overflow", overflow_flag, 8'h01);
    clock_select_field = tcu8_pkg::tcu8_cs_stopped;
    $display("test basic done");
  endtask
  task automatic t_ctc;
    compare_irq_enable = 1'b1;
    waveform_mode_field = tcu8_pkg::tcu8_wgm_ctc;
    wr_cmp(8'h03);
    check("direct compare", compare_value, 8'h03);
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    wr_cnt(8'h00);
    step(4);
    check("ctc clear", counter_value, 8'h00);
    check("flag not yet", compare_flag, 8'h00);
    step(1);
    check("flag set", compare_flag, 8'h01);
    check("irq", compare_irq, 8'h01);
    pulse(1);
    check("flag serviced", compare_flag, 8'h00);
    clock_select_field = tcu8_pkg::tcu8_cs_stopped;
    $display("test ctc done");
  endtask
  task automatic t_force;
    logic [7:0] held;
    held = counter_value;
    waveform_mode_field = tcu8_pkg::tcu8_wgm_normal;
    port_data = 1'b1;
    compare_output_mode_field = tcu8_pkg::tcu8_com_set;
    pulse(0);
    check("forced set", compare_pin_out, 8'h01);
    compare_output_mode_field = tcu8_pkg::tcu8_com_toggle;
    pulse(0);
    pulse(2);
    check("force flag", compare_flag, 8'h00);
    check("force counter", counter_value, held);
    compare_pin_direction = 1'b1;
    step(2);
    check("pin enable", compare_pin_oe, 8'h01);
    check("forced pin", pin_level, 8'h00);
    waveform_mode_field = tcu8_pkg::tcu8_wgm_ctc;
    compare_output_mode_field = tcu8_pkg::tcu8_com_none;
    step(2);
    check("port data pin", pin_level, 8'h01);
    compare_output_mode_field = tcu8_pkg::tcu8_com_toggle;
    pulse(0);
    step(1);
    check("toggled pin", pin_level, 8'h01);
    $display("test force done");
  endtask
  task automatic t_block;
    waveform_mode_field = tcu8_pkg::tcu8_wgm_normal;
    wr_cmp(8'h10);
    pulse(2);
    wr_cnt(8'h10);
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    step(4);
    check("blocked match", compare_flag, 8'h00);
    check("count after write", counter_value, 8'h14);
    for (int c = 2; c < 8; c++) begin
      clock_select_field = 3'(c);
      wr_cnt(8'h00);
      step(3 * divisor[c]);
      check("prescaled count", counter_value, 8'h03);
    end
    async_clock_select = 1'b1;
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    wr_cnt(8'h00);
    step(20);
    check("crystal still", counter_value, 8'h00);
    crystal_run = 1'b1;
    step(240);
    crystal_run = 1'b0;
    check("crystal ticks", 8'(counter_value >= 8'h14 && counter_value <= 8'h19), 8'h01);
    clock_select_field = tcu8_pkg::tcu8_cs_stopped;
    async_clock_select = 1'b0;
    $display("test block done");
  endtask
  task automatic t_pwm;
    int i;
    wr_cmp(8'h01);
    waveform_mode_field = tcu8_pkg::tcu8_wgm_fast_pwm;
    wr_cmp(8'h05);
    check("buffer readback", compare_value, 8'h05);
    pulse(2);
    pulse(3);
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    wr_cnt(8'h02);
    for (i = 0; i < 300 && compare_flag !== 1'b1; i++) begin
      step(1);
    end
    if (compare_flag !== 1'b1) begin
      err_count++;
      test_done();
    end
    check("match after top", counter_value, 8'h07);
    check("passed top", overflow_flag, 8'h01);
    clock_select_field = tcu8_pkg::tcu8_cs_stopped;
    waveform_mode_field = tcu8_pkg::tcu8_wgm_phase_pwm;
    wr_cnt(8'hfe);
    clock_select_field = tcu8_pkg::tcu8_cs_div1;
    step(3);
    check("down count", counter_value, 8'hfd);
    $display("test pwm done");
  endtask
  initial begin
    step(8);
    rst_b = 1'b1;
    step(1);
    t_basic();
    t_ctc();
    t_force();
    t_block();
    t_pwm();
    test_done();
  end
endmodule
